// ### design/lom_chan.sv
// One control output channel: smoothing filter and output forms
`timescale 1ns/10ps
`include "lom_defs.svh"
module lom_chan #(
	parameter int DAC_BIT_CYC = 1000
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic scan_tick,
	input wire logic cs_tick,
	input wire logic line_tick,
	input wire logic [6:0] demand,
	input wire logic [2:0] form,
	input wire logic [7:0] cycle_secs,
	input wire logic [7:0] filt_scans,
	input wire logic dac_mode,
	output logic drive
);
	logic [14:0] filt_q;
	logic [15:0] tp_cnt;
	logic [14:0] on_cs;
	logic [7:0] zc_acc;
	logic [1:0] hold_cnt;
	logic zc_on;
	logic [9:0] dac_sh;
	logic [3:0] dac_bits;
	logic [15:0] dac_tmr;
	wire lom_pkg::lom_form_t fm = lom_pkg::lom_form_t'(form);
	wire signed [16:0] f_diff = $signed({2'b00, demand, 8'h00}) - $signed({2'b00, filt_q});
	wire signed [16:0] f_step = f_diff / $signed({9'h000, filt_scans});
	wire [14:0] next_filt = (filt_scans == 8'h00) ? {demand, 8'h00} : 15'(filt_q + 15'(f_step)); // R16 R19
	wire [6:0] fdem = (fm == lom_pkg::FORM_ONOFF) ? demand : filt_q[14:8];
	wire [7:0] cyc = (cycle_secs == 8'h00) ? 8'h01 : cycle_secs;
	wire [15:0] cyc_cs = 16'(cyc) * 16'(`LOM_PCT_FULL);
	wire tp_start = (tp_cnt == 16'h0000);
	wire [7:0] next_acc = zc_acc + {1'b0, fdem};
	wire zc_decide = line_tick & ((fm == lom_pkg::FORM_DZC) | (hold_cnt == 2'h0)); // R13
	wire use_dac = dac_mode | (fm == lom_pkg::FORM_ANALOG); // R15
	wire [7:0] dac_code = 8'((16'(fdem) * 16'h00FF) / 16'h0064); // R14
	logic next_drive;
	always_comb
	begin
		unique case (fm)
			lom_pkg::FORM_ONOFF: next_drive = (demand != 7'h00); // R8
			lom_pkg::FORM_TP: next_drive = ({1'b0, tp_cnt[14:0]} < {1'b0, on_cs}) & ~tp_start | (tp_start & fdem != 7'h00);
			lom_pkg::FORM_DZC, lom_pkg::FORM_DZC3: next_drive = zc_on;
			default: next_drive = 1'b0;
		endcase
		if (use_dac)
			next_drive = dac_sh[0];
	end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			filt_q <= 15'h0000;
			tp_cnt <= 16'h0000;
			on_cs <= 15'h0000;
			zc_acc <= 8'h00;
			hold_cnt <= 2'h0;
			zc_on <= 1'b0;
			dac_sh <= 10'h000;
			dac_bits <= 4'h0;
			dac_tmr <= 16'h0000;
			drive <= 1'b0;
		end
		else if (ce)
		begin
			drive <= next_drive;
			if (scan_tick)
				filt_q <= next_filt; // R19
			if (cs_tick)
			begin
				tp_cnt <= (tp_cnt + 16'h0001 >= cyc_cs) ? 16'h0000 : tp_cnt + 16'h0001; // R10
				if (tp_start)
					on_cs <= 15'(fdem) * 15'(cyc); // R20
			end
			if (line_tick)
				hold_cnt <= (hold_cnt == 2'h2) ? 2'h0 : hold_cnt + 2'h1;
			if (zc_decide)
			begin
				// Sigma-delta spreads on-cycles evenly over line cycles
				zc_on <= (next_acc >= 8'h64); // R11
				zc_acc <= (next_acc >= 8'h64) ? next_acc - 8'h64 : next_acc;
			end
			// Frame: start bit, eight data bits msb first, stop bit
			if (dac_bits == 4'h0)
			begin
				dac_sh <= 10'h000;
				if (scan_tick & use_dac)
				begin
					dac_sh <= {1'b1, ~dac_code[0], ~dac_code[1], ~dac_code[2], ~dac_code[3],
						~dac_code[4], ~dac_code[5], ~dac_code[6], ~dac_code[7], 1'b1};
					dac_bits <= 4'hA;
					dac_tmr <= 16'(DAC_BIT_CYC - 1);
				end
			end
			else if (dac_tmr == 16'h0000)
			begin
				dac_sh <= {1'b0, dac_sh[9:1]};
				dac_bits <= dac_bits - 4'h1;
				dac_tmr <= 16'(DAC_BIT_CYC - 1);
			end
			else
				dac_tmr <= dac_tmr - 16'h0001;
		end
	end
endmodule : lom_chan

// ### design/lom_loop_output_modulator.sv
// Loop output modulator top: register slave, control algorithms, profile recovery
//
// Overview of operation
// (R1) On/off: heat on below set point minus spread, off above set point.
// (R2) Proportional: 0% at set point, 100% at set point minus band, linear between.
// (R3) Integral action keeps nudging output until steady deviation is gone.
// (R4) Derivative action cuts output when the process rises fast toward set point.
// (R5) Algorithms act only in automatic mode; otherwise the manual level is used.
// (R6) A loop drives one output, or heat and cool outputs from one input.
// (R7) Heat/cool changeover uses the spread band plus PID to avoid toggling.
// (R8) On/off form gives only fully off or fully on, no PID.
// (R9) Proportioned, zero-cross and analog forms use a demand clamped to 0..100%.
// (R10) Time-proportioned output is on for demand share of a 1..255 s cycle.
// (R11) Zero-cross form decides on or off per line cycle, spreading on-cycles.
// (R12) The external zero-cross switch changes state only at line zero crossings.
// (R13) Three-phase zero-cross holds each state at least three line cycles.
// (R14) Analog form sends the demand share of full scale to a serial DAC.
// (R15) Each output is configurable as relay drive or serial DAC drive line.
// (R16) Output smoothing set in scans, 0..255, zero meaning no smoothing.
// (R17) By default a profile interrupted by power loss returns to ready.
// (R18) With memory recovery the profile resumes its segment at its elapsed time.
// (R19) Smoothing is a first-order low-pass, once per scan, time constant in scans.
// (R20) On-time is demand times cycle, refreshed at each cycle start.
`timescale 1ns/10ps
`include "lom_defs.svh"
module lom_loop_output_modulator #(
	parameter int CS_CYCLES = `LOM_CS_TICK_NS / `LOM_CLK_NS,
	parameter int DAC_BIT_CYC = `LOM_DAC_BIT_NS / `LOM_CLK_NS
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic scan_tick,
	input wire logic line_zc,
	input wire logic power_restored,
	output logic [1:0] ctl_out,
	output logic [1:0] ctl_oe
);
	localparam int CS_W = $clog2(CS_CYCLES + 1);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge

	function automatic logic signed [7:0] sat_pct(input logic signed [33:0] v);
		if (v > 34'sd100)
			return 8'sd100;
		else if (v < -34'sd100)
			return -8'sd100;
		else
			return 8'(v);
	endfunction : sat_pct

	logic [31:0] ctrl;
	logic [15:0] setpt;
	logic [15:0] pv;
	logic [31:0] band;
	logic [31:0] tune;
	logic zc_s1;
	logic zc_s2;
	logic zc_s3;
	logic [CS_W-1:0] cs_cnt;
	logic cs_tick;
	logic [6:0] cs_sec;
	logic signed [15:0] pv_prev;
	logic signed [23:0] integ;
	logic heat_on;
	logic cool_on;
	logic cool_side;
	logic [6:0] heat_dem;
	logic [6:0] cool_dem;
	lom_pkg::lom_prof_t prof;
	logic [7:0] seg;
	logic [15:0] elapsed;

	// Bus decode
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = req & wb_we_i;
	wire hit_ctrl = (wb_adr_i == `LOM_ADR_CTRL);
	wire hit_sp = (wb_adr_i == `LOM_ADR_SETPT);
	wire hit_pv = (wb_adr_i == `LOM_ADR_PV);
	wire hit_band = (wb_adr_i == `LOM_ADR_BAND);
	wire hit_tune = (wb_adr_i == `LOM_ADR_TUNE);
	wire hit_prof = (wb_adr_i == `LOM_ADR_PROF);
	wire hit_stat = (wb_adr_i == `LOM_ADR_STAT);
	wire [31:0] wmerge = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
	wire [31:0] sp_merge = merge({16'h0000, setpt}, wb_dat_i, wb_sel_i & 4'h3);
	wire [31:0] pv_merge = merge({16'h0000, pv}, wb_dat_i, wb_sel_i & 4'h3);
	wire prof_cmd = wr & hit_prof & wb_sel_i[3];
	wire [31:0] rd_data =
		hit_ctrl ? (ctrl & `LOM_CTRL_MASK) :
		hit_sp ? {16'h0000, setpt} :
		hit_pv ? {16'h0000, pv} :
		hit_band ? band :
		hit_tune ? (tune & `LOM_TUNE_MASK) :
		hit_prof ? {6'h00, prof, elapsed, seg} :
		hit_stat ? {13'h0000, cool_side, cool_on, heat_on, 1'b0, cool_dem, 1'b0, heat_dem} :
		32'h0000_0000;

	// Configuration fields
	wire auto_mode = ctrl[`LOM_B_AUTO];
	wire dual = ctrl[`LOM_B_DUAL];
	wire lom_pkg::lom_form_t form = lom_pkg::lom_form_t'(ctrl[`LOM_F_FORM]);
	wire onoff = (form == lom_pkg::FORM_ONOFF);
	wire [6:0] manual = (ctrl[`LOM_F_MANUAL] > `LOM_PCT_FULL) ? `LOM_PCT_FULL : ctrl[`LOM_F_MANUAL];
	wire [15:0] hyst = band[`LOM_F_HYST];
	wire [15:0] pb = (band[`LOM_F_PB] == 16'h0000) ? 16'h0001 : band[`LOM_F_PB];
	wire [3:0] ishift = tune[`LOM_F_ISHIFT];
	wire [7:0] dgain = tune[`LOM_F_DGAIN];

	// Error terms, heat side reverse acting
	wire signed [16:0] sp_x = $signed({setpt[15], setpt});
	wire signed [16:0] pv_x = $signed({pv[15], pv});
	wire signed [16:0] err = sp_x - pv_x;
	wire signed [16:0] dpv = pv_x - $signed({pv_prev[15], pv_prev});
	wire signed [17:0] sp_lo = $signed({sp_x[16], sp_x}) - $signed({2'b00, hyst});
	wire signed [17:0] sp_hi = $signed({sp_x[16], sp_x}) + $signed({2'b00, hyst});
	wire signed [17:0] pv_w = $signed({pv_x[16], pv_x});
	wire signed [17:0] sp_w = $signed({sp_x[16], sp_x});
	wire signed [23:0] i_term = ctrl[`LOM_B_INT] ? (integ >>> ishift) : 24'sd0; // R3
	wire signed [25:0] d_term = ctrl[`LOM_B_DER] ? (dpv * $signed({1'b0, dgain})) : 26'sd0; // R4
	wire signed [26:0] num = 27'(err) + 27'(i_term) - 27'(d_term);
	// Divide by the band maps a full band of error onto 100%
	wire signed [33:0] scaled = 34'(num) * 34'sd100;
	wire signed [33:0] pct = scaled / $signed({18'h0_0000, pb}); // R2
	wire signed [7:0] raw = sat_pct(pct); // R9
	wire [6:0] heat_pid = (raw > 8'sd0) ? raw[6:0] : 7'h00;
	wire [6:0] cool_pid = (raw < 8'sd0) ? 7'(-raw) : 7'h00;
	wire signed [23:0] int_sum = integ + 24'(err);
	wire signed [23:0] next_integ =
		(int_sum > $signed(`LOM_INT_LIMIT)) ? $signed(`LOM_INT_LIMIT) :
		(int_sum < -$signed(`LOM_INT_LIMIT)) ? -$signed(`LOM_INT_LIMIT) : int_sum;

	// On/off thresholds, cool side mirrors heat
	wire next_heat_on = (pv_w < sp_lo) ? 1'b1 : (pv_w > sp_w) ? 1'b0 : heat_on; // R1
	wire next_cool_on = dual & ((pv_w > sp_hi) ? 1'b1 : (pv_w < sp_w) ? 1'b0 : cool_on);
	wire next_cool_side = dual & ((pv_w > sp_hi) ? 1'b1 : (pv_w < sp_lo) ? 1'b0 : cool_side); // R7

	logic [6:0] next_heat;
	logic [6:0] next_cool;
	always_comb
	begin
		if (!auto_mode)
		begin
			next_heat = manual; // R5
			next_cool = 7'h00;
		end
		else if (onoff)
		begin
			next_heat = next_heat_on ? `LOM_PCT_FULL : 7'h00; // R8
			next_cool = next_cool_on ? `LOM_PCT_FULL : 7'h00;
		end
		else
		begin
			// Only the side chosen by the changeover band may drive
			next_heat = next_cool_side ? 7'h00 : heat_pid; // R7
			next_cool = (dual & next_cool_side) ? cool_pid : 7'h00; // R6
		end
	end

	// Bus slave: ack one cycle after the request, zero for unmapped reads
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else if (ce)
		begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_data : 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl <= `LOM_CTRL_RST;
			setpt <= 16'h0000;
			pv <= 16'h0000;
			band <= `LOM_BAND_RST;
			tune <= `LOM_TUNE_RST;
		end
		else if (ce & wr)
		begin
			if (hit_ctrl)
				ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
			if (hit_sp)
				setpt <= sp_merge[15:0];
			if (hit_pv)
				pv <= pv_merge[15:0];
			if (hit_band)
				band <= merge(band, wb_dat_i, wb_sel_i);
			if (hit_tune)
				tune <= merge(tune, wb_dat_i, wb_sel_i);
		end
	end

	// Line zero-cross pin, two-stage synchroniser then edge detect
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			zc_s1 <= 1'b0;
			zc_s2 <= 1'b0;
			zc_s3 <= 1'b0;
		end
		else if (ce)
		begin
			zc_s1 <= line_zc;
			zc_s2 <= zc_s1;
			zc_s3 <= zc_s2;
		end
	end
	wire line_tick = zc_s2 & ~zc_s3; // R12

	// Centisecond tick drives cycle timing and segment time
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cs_cnt <= '0;
			cs_tick <= 1'b0;
			cs_sec <= 7'h00;
		end
		else if (ce)
		begin
			cs_tick <= (cs_cnt == CS_W'(CS_CYCLES - 1));
			cs_cnt <= (cs_cnt == CS_W'(CS_CYCLES - 1)) ? '0 : cs_cnt + 1'b1;
			if (cs_tick)
				cs_sec <= (cs_sec == `LOM_CS_PER_SEC) ? 7'h00 : cs_sec + 7'h01;
		end
	end
	wire sec_tick = cs_tick & (cs_sec == `LOM_CS_PER_SEC);

	// Control state updates once per scan
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pv_prev <= 16'sd0;
			integ <= 24'sd0;
			heat_on <= 1'b0;
			cool_on <= 1'b0;
			cool_side <= 1'b0;
			heat_dem <= 7'h00;
			cool_dem <= 7'h00;
		end
		else if (ce & scan_tick)
		begin
			pv_prev <= $signed(pv);
			heat_dem <= next_heat;
			cool_dem <= next_cool;
			if (auto_mode)
			begin
				heat_on <= next_heat_on;
				cool_on <= next_cool_on;
				cool_side <= next_cool_side;
				// Windup limited; frozen outside automatic so transfer is bumpless
				if (ctrl[`LOM_B_INT] & ~onoff)
					integ <= next_integ; // R3
			end
		end
	end

	// Ramp/soak profile position and power-restore policy
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			prof <= lom_pkg::PROF_READY;
			seg <= 8'h00;
			elapsed <= 16'h0000;
		end
		else if (ce)
		begin
			if (power_restored & (prof != lom_pkg::PROF_READY))
			begin
				if (ctrl[`LOM_B_MEMREC])
					prof <= lom_pkg::PROF_RUN; // R18
				else
				begin
					prof <= lom_pkg::PROF_READY; // R17
					seg <= 8'h00;
					elapsed <= 16'h0000;
				end
			end
			else if (prof_cmd & wmerge[`LOM_B_RESET])
			begin
				prof <= lom_pkg::PROF_READY;
				seg <= 8'h00;
				elapsed <= 16'h0000;
			end
			else if (prof_cmd & wmerge[`LOM_B_START] & (prof == lom_pkg::PROF_READY))
				prof <= lom_pkg::PROF_RUN;
			else if (prof_cmd & wmerge[`LOM_B_HOLD] & (prof == lom_pkg::PROF_RUN))
				prof <= lom_pkg::PROF_HOLD;
			else if (prof_cmd & wmerge[`LOM_B_CONT] & (prof == lom_pkg::PROF_HOLD))
				prof <= lom_pkg::PROF_RUN;
			else
			begin
				if (wr & hit_prof & wb_sel_i[0])
				begin
					seg <= wb_dat_i[`LOM_F_SEG];
					elapsed <= 16'h0000;
				end
				else if (sec_tick & (prof == lom_pkg::PROF_RUN))
					elapsed <= elapsed + 16'h0001;
			end
		end
	end

	// Open-collector outputs only sink, so the level is always low
	logic [1:0] chan_drive;
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : chan
			lom_chan #(
				.DAC_BIT_CYC(DAC_BIT_CYC)
			) u_chan (
				.ref_clk(ref_clk),
				.rst(rst),
				.ce(ce),
				.scan_tick(scan_tick),
				.cs_tick(cs_tick),
				.line_tick(line_tick),
				.demand((g == 0) ? heat_dem : cool_dem),
				.form(ctrl[`LOM_F_FORM]),
				.cycle_secs(tune[`LOM_F_CYCLE]),
				.filt_scans(tune[`LOM_F_FILT]),
				.dac_mode(ctrl[`LOM_B_DAC0 + g]), // R15
				.drive(chan_drive[g])
			);
		end
	endgenerate

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ctl_out <= 2'b00;
			ctl_oe <= 2'b00;
		end
		else if (ce)
		begin
			ctl_out <= 2'b00;
			ctl_oe <= {chan_drive[1] & dual, chan_drive[0]}; // R6
		end
	end
endmodule : lom_loop_output_modulator

// ### shared/lom_defs.svh
// Register map, field positions, reset values and timing for the loop output modulator
`ifndef LOM_DEFS_SVH
`define LOM_DEFS_SVH
`define LOM_ADR_CTRL 8'h00
`define LOM_ADR_SETPT 8'h04
`define LOM_ADR_PV 8'h08
`define LOM_ADR_BAND 8'h0C
`define LOM_ADR_TUNE 8'h10
`define LOM_ADR_PROF 8'h14
`define LOM_ADR_STAT 8'h18
`define LOM_CTRL_MASK 32'h007F_03FF
`define LOM_TUNE_MASK 32'h0FFF_FFFF
`define LOM_CTRL_RST 32'h0000_0002
`define LOM_TUNE_RST 32'h0000_0014
`define LOM_BAND_RST 32'h0014_0014
`define LOM_B_AUTO 0
`define LOM_F_FORM 3:1
`define LOM_B_DUAL 4
`define LOM_B_INT 5
`define LOM_B_DER 6
`define LOM_B_DAC0 7
`define LOM_B_MEMREC 9
`define LOM_F_MANUAL 22:16
`define LOM_F_HYST 15:0
`define LOM_F_PB 31:16
`define LOM_F_CYCLE 7:0
`define LOM_F_FILT 15:8
`define LOM_F_ISHIFT 19:16
`define LOM_F_DGAIN 27:20
`define LOM_F_SEG 7:0
`define LOM_B_START 24
`define LOM_B_HOLD 25
`define LOM_B_CONT 26
`define LOM_B_RESET 27
`define LOM_PCT_FULL 7'h64
`define LOM_INT_LIMIT 24'h0F_FFFF
`define LOM_CS_PER_SEC 7'h63
`define LOM_CLK_NS 10
`define LOM_CS_TICK_NS 10000000
`define LOM_DAC_BIT_NS 10000
`endif

// ### shared/lom_pkg.sv
// Types shared by the loop output modulator files
package lom_pkg;
	typedef enum logic [2:0] {FORM_ONOFF, FORM_TP, FORM_DZC, FORM_DZC3, FORM_ANALOG} lom_form_t;
	typedef enum logic [1:0] {PROF_READY, PROF_RUN, PROF_HOLD} lom_prof_t;
endpackage : lom_pkg

// ### tb/lom_checker.sv
// Port checker for the loop output modulator
`timescale 1ns/10ps
module lom_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [1:0] ctl_out,
	input wire logic [1:0] ctl_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
		else $error("ack missing");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("data outside ack");
	a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h18
		|-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
	a_ctrl_rsvd: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h00
		|-> wb_dat_o[31:23] == 9'h000 && wb_dat_o[15:10] == 6'h00) else $error("reserved bits set");
	a_sink_only: assert property (ctl_out == 2'h0)
		else $error("output drives high");
	a_reset_quiet: assert property ($past(rst) |-> !wb_ack_o && ctl_oe == 2'h0)
		else $error("outputs active after reset");
	a_ce_freeze: assert property (!ce |=> $stable(ctl_oe) && $stable(wb_ack_o))
		else $error("state moved while frozen");
endmodule : lom_checker
bind lom_loop_output_modulator lom_checker lom_checker_inst (.ref_clk, .rst, .ce, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .ctl_out, .ctl_oe);

// ### tb/lom_partner.sv
// Line source, zero-cross relay and serial converter model
`timescale 1ns/10ps
module lom_partner #(
	parameter int LINE_HALF = 50,
	parameter int BIT_CYC = 4
) (
	input wire logic ref_clk,
	input wire logic [1:0] ctl_oe,
	output logic line_zc,
	output logic ssr_on,
	output logic [7:0] dac_code,
	output int dac_frames
);
	initial line_zc = 1'b0;
	initial ssr_on = 1'b0;
	initial dac_code = 8'h00;
	initial dac_frames = 0;
	always
	begin
		repeat (LINE_HALF) @(posedge ref_clk);
		line_zc <= ~line_zc;
	end
	// Relay only switches at a line zero crossing
	always @(posedge line_zc)
		ssr_on <= ctl_oe[0];
	// Sample mid-bit, data arrives inverted
	always
	begin
		@(posedge ctl_oe[0]);
		repeat (BIT_CYC + BIT_CYC / 2) @(posedge ref_clk);
		for (int i = 7; i >= 0; i--)
		begin
			dac_code[i] <= ~ctl_oe[0];
			repeat (BIT_CYC) @(posedge ref_clk);
		end
		dac_frames <= dac_frames + 1;
	end
endmodule : lom_partner

// ### tb/testbench.sv
// Self-checking bench for the loop output modulator
`timescale 1ns/10ps
`include "lom_defs.svh"
module testbench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic scan_tick = 1'b0;
	logic line_zc;
	logic power_restored = 1'b0;
	logic [1:0] ctl_out;
	logic [1:0] ctl_oe;
	logic ssr_on;
	logic prev;
	logic [7:0] dac_code;
	logic [31:0] rd;
	int dac_frames;
	int failures = 0;
	int n_checks = 0;
	int cnt;
	int run;
	int short_runs;
	int changes;
	logic [31:0] pv_tab [6] = '{32'h0000_03E8, 32'h0000_03DE, 32'h0000_03D9, 32'h0000_03D4, 32'h0000_03C0,
		32'h0000_03FC};
	logic [31:0] pct_tab [6] = '{32'h0000_0000, 32'h0000_0032, 32'h0000_004B, 32'h0000_0064, 32'h0000_0064,
		32'h0000_0000};
	logic [31:0] oo_pv [8] = '{32'h0000_03CA, 32'h0000_03DE, 32'h0000_03F2, 32'h0000_03DE, 32'h0000_0406,
		32'h0000_03F2, 32'h0000_03DE, 32'h0000_03CA};
	logic [1:0] oo_oe [8] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h1};
	always #5 ref_clk = ~ref_clk;
	// Short second and bit time keep the run brief
	lom_loop_output_modulator #(.CS_CYCLES(10), .DAC_BIT_CYC(4)) lom_loop_output_modulator_inst (.ref_clk, .rst,
		.ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .scan_tick,
		.line_zc, .power_restored, .ctl_out, .ctl_oe);
	lom_partner #(.LINE_HALF(50), .BIT_CYC(4)) lom_partner_inst (.ref_clk, .ctl_oe, .line_zc, .ssr_on,
		.dac_code, .dac_frames);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [3:0] sel, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= sel;
		wb_dat_i <= d;
		// Only the watchdog ends a wait for ack
		do
			@(posedge ref_clk);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask : wb_xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb_xfer(1'b1, a, 4'hF, d);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb_xfer(1'b0, a, 4'hF, 32'h0000_0000);
		check(rd & m, e);
	endtask : rchk
	task automatic scan(input int n);
		repeat (n)
		begin
			scan_tick <= 1'b1;
			@(posedge ref_clk);
			scan_tick <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask : scan
	task automatic dac_scan;
		int f;
		f = dac_frames;
		scan(1);
		repeat (100)
			if (dac_frames == f)
				@(posedge ref_clk);
		check(32'(dac_frames - f), 32'h0000_0001);
	endtask : dac_scan
	task automatic restore;
		power_restored <= 1'b1;
		@(posedge ref_clk);
		power_restored <= 1'b0;
		@(posedge ref_clk);
	endtask : restore
	task automatic prof_run(input logic hold);
		wb_xfer(1'b1, `LOM_ADR_PROF, 4'h8, 32'h0100_0000);
		wb_xfer(1'b1, `LOM_ADR_PROF, 4'h1, 32'h0000_0003);
		repeat (2500) @(posedge ref_clk);
		if (hold)
			wb_xfer(1'b1, `LOM_ADR_PROF, 4'h8, 32'h0200_0000);
		restore();
	endtask : prof_run
	task automatic finish_test;
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		failures++;
		finish_test();
	end
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		rchk(`LOM_ADR_CTRL, 32'hFFFF_FFFF, `LOM_CTRL_RST);
		rchk(`LOM_ADR_BAND, 32'hFFFF_FFFF, `LOM_BAND_RST);
		rchk(`LOM_ADR_TUNE, 32'hFFFF_FFFF, `LOM_TUNE_RST);
		rchk(`LOM_ADR_PROF, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(8'h40, 32'hFFFF_FFFF);
		rchk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(`LOM_ADR_SETPT, 32'h0000_03E8);
		wr(`LOM_ADR_PV, 32'h0000_0384);
		wr(`LOM_ADR_CTRL, 32'h0028_0002);
		scan(1);
		rchk(`LOM_ADR_STAT, 32'h0000_007F, 32'h0000_0028);
		wr(`LOM_ADR_CTRL, 32'h0000_0003);
		foreach (pv_tab[i])
		begin
			wr(`LOM_ADR_PV, pv_tab[i]);
			scan(1);
			rchk(`LOM_ADR_STAT, 32'h0000_007F, pct_tab[i]);
		end
		wr(`LOM_ADR_TUNE, 32'h0010_0014);
		wr(`LOM_ADR_CTRL, 32'h0000_0043);
		wr(`LOM_ADR_PV, 32'h0000_03DE);
		scan(2);
		wr(`LOM_ADR_PV, 32'h0000_03E3);
		scan(1);
		rchk(`LOM_ADR_STAT, 32'h0000_007F, 32'h0000_0000);
		wr(`LOM_ADR_TUNE, 32'h0000_0014);
		// Steady 5 degree error, integral adds one error per scan
		wr(`LOM_ADR_CTRL, 32'h0000_0023);
		scan(3);
		rchk(`LOM_ADR_STAT, 32'h0000_007F, 32'h0000_004B);
		wr(`LOM_ADR_CTRL, 32'h0000_0001);
		for (int i = 0; i < 8; i++)
		begin
			if (i == 4)
				wr(`LOM_ADR_CTRL, 32'h0000_0011);
			wr(`LOM_ADR_PV, oo_pv[i]);
			scan(1);
			rchk(`LOM_ADR_STAT, 32'h0003_0000, {14'h0000, oo_oe[i], 16'h0000});
			check({30'h0000_0000, ctl_oe}, {30'h0000_0000, oo_oe[i]});
		end
		// One second cycle, 30% gives 300 of every 1000 clocks
		wr(`LOM_ADR_TUNE, 32'h0000_0001);
		wr(`LOM_ADR_CTRL, 32'h001E_0002);
		// Filter follows the latched demand one scan later
		scan(2);
		repeat (1100) @(posedge ref_clk);
		cnt = 0;
		repeat (3000)
		begin
			@(posedge ref_clk);
			cnt += ctl_oe[0];
		end
		check(32'(cnt), 32'h0000_0384);
		wr(`LOM_ADR_CTRL, 32'h0019_0004);
		scan(2);
		repeat (3) @(posedge line_zc);
		cnt = 0;
		repeat (40)
		begin
			@(posedge line_zc);
			#1;
			cnt += ssr_on;
		end
		check(32'(cnt), 32'h0000_000A);
		@(posedge ref_clk);
		wr(`LOM_ADR_CTRL, 32'h0032_0006);
		scan(1);
		repeat (4) @(posedge line_zc);
		#1;
		prev = ssr_on;
		run = 0;
		short_runs = 0;
		changes = 0;
		repeat (30)
		begin
			@(posedge line_zc);
			#1;
			if (ssr_on !== prev)
			begin
				if (changes > 0 && run < 3)
					short_runs++;
				changes++;
				run = 0;
				prev = ssr_on;
			end
			run++;
		end
		check(32'(short_runs), 32'h0000_0000);
		check(32'(changes > 3), 32'h0000_0001);
		@(posedge ref_clk);
		wr(`LOM_ADR_CTRL, 32'h0032_0008);
		repeat (100) @(posedge ref_clk);
		dac_scan();
		dac_scan();
		check({24'h00_0000, dac_code}, 32'h0000_007F);
		wr(`LOM_ADR_TUNE, 32'h0000_0201);
		// Step 50 to 100 through a two-scan filter is halfway after one scan
		wr(`LOM_ADR_CTRL, 32'h0064_0082);
		dac_scan();
		dac_scan();
		dac_scan();
		check({24'h00_0000, dac_code}, 32'h0000_00BF);
		// Frozen clock enable holds all state
		ce <= 1'b0;
		repeat (5) @(posedge ref_clk);
		ce <= 1'b1;
		prof_run(1'b0);
		rchk(`LOM_ADR_PROF, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(`LOM_ADR_CTRL, 32'h0000_0202);
		prof_run(1'b1);
		rchk(`LOM_ADR_PROF, 32'h0300_00FF, 32'h0100_0003);
		check(32'((rd & 32'h00FF_FF00) != 0), 32'h0000_0001);
		finish_test();
	end
endmodule : testbench
